// ==== pkg/ccm2_pkg.sv ====
package ccm2_pkg;

  // ***********************************************
  // register map and fields
  // ***********************************************
  localparam logic [7:0] CCM2_OFS_CFG = 8'h00;
  localparam logic [7:0] CCM2_OFS_CCR = 8'h04;
  localparam logic [7:0] CCM2_OFS_STAT = 8'h08;
  localparam int CCM2_DIR_LSB = 8;
  localparam int CCM2_FE_BIT = 10;
  localparam int CCM2_BE_BIT = 11;
  localparam int CCM2_OM_LSB = 12;
  localparam int CCM2_FLT_LSB = 12;
  localparam logic [15:0] CCM2_CFG_RST = 16'h0000;
  localparam logic [1:0] CCM2_DIR_OUT = 2'h0;
  localparam logic [1:0] CCM2_OKAY = 2'h0;
  localparam logic [1:0] CCM2_SLVERR = 2'h2;

  // output modes
  localparam logic [2:0] CCM2_OM_FRZ = 3'h0;
  localparam logic [2:0] CCM2_OM_SET = 3'h1;
  localparam logic [2:0] CCM2_OM_CLR = 3'h2;
  localparam logic [2:0] CCM2_OM_TOG = 3'h3;
  localparam logic [2:0] CCM2_OM_FLO = 3'h4;
  localparam logic [2:0] CCM2_OM_FHI = 3'h5;
  localparam logic [2:0] CCM2_OM_PWM1 = 3'h6;
  localparam logic [2:0] CCM2_OM_PWM2 = 3'h7;

  // ***********************************************
  // carriers
  // ***********************************************
  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic rready;
  } ccm2_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ccm2_axi_rsp_s;

  typedef struct packed {
    logic [2:0] div_log2;
    logic [3:0] n;
  } ccm2_flt_s;

  // filter code to sample divisor and count
  function automatic ccm2_flt_s ccm2_flt_lookup(input logic [3:0] c);
    ccm2_flt_s f;
    f = '{3'h0, 4'h1};
    case (c)
      4'h0: f = '{3'h0, 4'h1};
      4'h1: f = '{3'h0, 4'h2};
      4'h2: f = '{3'h0, 4'h4};
      4'h3: f = '{3'h0, 4'h8};
      4'h4: f = '{3'h1, 4'h6};
      4'h5: f = '{3'h1, 4'h8};
      4'h6: f = '{3'h2, 4'h6};
      4'h7: f = '{3'h2, 4'h8};
      4'h8: f = '{3'h3, 4'h6};
      4'h9: f = '{3'h3, 4'h8};
      4'ha: f = '{3'h4, 4'h5};
      4'hb: f = '{3'h4, 4'h6};
      4'hc: f = '{3'h4, 4'h8};
      4'hd: f = '{3'h5, 4'h5};
      4'he: f = '{3'h5, 4'h6};
      4'hf: f = '{3'h5, 4'h8};
      default: f = '{3'h0, 4'h1};
    endcase
    return f;
  endfunction

endpackage

// ==== logic/ccm2_top.sv ====
// The address map and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/100ps
module ccm2_top
  import ccm2_pkg::*;
#(
  parameter int CW = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire ccm2_axi_req_s axi_req,
  output ccm2_axi_rsp_s axi_rsp,
  input wire logic update_event,
  input wire logic one_pulse_select,
  input wire logic [CW-1:0] counter_value,
  input wire logic trigger_pin,
  input wire logic ch2_timer_input,
  output logic ch2_output_pin,
  output logic ch2_filtered,
  output logic trigger_to_core,
  output logic [CW-1:0] ch2_shadow_value
);

  // ***********************************************
  // elaboration checks
  // ***********************************************
  if (CW < 1 || CW > 32) begin : g_bad_cw
    $error("ccm2_top: CW must lie in 1..32");
  end

  // ***********************************************
  // state
  // ***********************************************
  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [15:0] cfg;
    logic [CW-1:0] pre;
    logic [CW-1:0] shd;
    logic [1:0] trg_s;
    logic trg_p;
    logic trg;
    logic [1:0] ti_s;
    logic [4:0] div;
    logic [3:0] cnt;
    logic filt;
    logic oref;
  } ccm2_state_s;

  ccm2_state_s q;
  ccm2_state_s d;

  // ***********************************************
  // decoded configuration
  // ***********************************************
  logic out_dir;
  logic buf_en;
  logic [2:0] om;
  logic pwm;
  logic fast_act;
  logic trg_edge;
  logic [3:0] fcode;
  logic code0;
  ccm2_flt_s flt;
  logic [4:0] div_max;
  logic samp;
  logic match;
  logic below;
  logic warn;

  // direction gates every output-side bit
  assign out_dir = q.cfg[CCM2_DIR_LSB+:2] == CCM2_DIR_OUT;
  assign buf_en = out_dir && q.cfg[CCM2_BE_BIT];
  assign om = q.cfg[CCM2_OM_LSB+:3];
  assign pwm = om == CCM2_OM_PWM1 || om == CCM2_OM_PWM2;
  assign fast_act = out_dir && q.cfg[CCM2_FE_BIT] && pwm;
  // rising edge taken only from the second sync stage
  assign trg_edge = q.trg_s[1] && !q.trg_p;
  assign fcode = q.cfg[CCM2_FLT_LSB+:4];
  // an output channel bypasses the filter entirely
  assign code0 = out_dir || fcode == 4'h0;
  assign flt = ccm2_flt_lookup(fcode);
  assign div_max = 5'((6'h01 << flt.div_log2) - 6'h01);
  assign samp = q.div == div_max;
  assign match = counter_value == q.shd;
  assign below = counter_value < q.shd;
  // unbuffered pwm outside one-pulse is software's fault
  assign warn = out_dir && pwm && !q.cfg[CCM2_BE_BIT] &&
                !one_pulse_select;

  // merge a strobed write into an old word
  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0] s);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    return (old & ~m) | (wd & m);
  endfunction

  // ***********************************************
  // next state
  // ***********************************************
  always_comb begin
    d = q;
    // write channels taken in either order
    if (axi_req.awvalid && q.awready) begin
      d.aw_got = 1'b1;
      d.awaddr = axi_req.awaddr[7:0];
    end
    if (axi_req.wvalid && q.wready) begin
      d.w_got = 1'b1;
      d.wdata = axi_req.wdata;
      d.wstrb = axi_req.wstrb;
    end
    if (q.bvalid && axi_req.bready) begin
      d.bvalid = 1'b0;
    end
    // buffered value moves to shadow on update
    if (buf_en && update_event) begin
      d.shd = q.pre;
    end
    if (q.aw_got && q.w_got) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = CCM2_OKAY;
      case (q.awaddr)
        CCM2_OFS_CFG: begin
          d.cfg = 16'(wmerge(32'(q.cfg), q.wdata, q.wstrb));
        end
        CCM2_OFS_CCR: begin
          if (buf_en) begin
            d.pre = CW'(wmerge(32'(q.pre), q.wdata, q.wstrb));
          end else begin
            d.pre = CW'(wmerge(32'(q.shd), q.wdata, q.wstrb));
            d.shd = d.pre;
          end
        end
        CCM2_OFS_STAT: begin
        end
        default: begin
          d.bresp = CCM2_SLVERR;
        end
      endcase
    end
    d.awready = !d.aw_got && !d.bvalid;
    d.wready = !d.w_got && !d.bvalid;

    // read channel, buffered value seen when buffered
    if (q.rvalid && axi_req.rready) begin
      d.rvalid = 1'b0;
    end
    if (axi_req.arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rresp = CCM2_OKAY;
      case (axi_req.araddr[7:0])
        CCM2_OFS_CFG: d.rdata = 32'(q.cfg);
        CCM2_OFS_CCR: d.rdata = 32'(buf_en ? q.pre : q.shd);
        CCM2_OFS_STAT: d.rdata = {29'h0, warn, q.oref, q.filt};
        default: begin
          d.rdata = 32'h0;
          d.rresp = CCM2_SLVERR;
        end
      endcase
    end
    d.arready = !d.rvalid;

    // trigger sync and pulse towards the counter core
    d.trg_s = {q.trg_s[0], trigger_pin};
    d.trg_p = q.trg_s[1];
    d.trg = trg_edge;

    // output reference from the comparison
    if (out_dir) begin
      case (om)
        CCM2_OM_FRZ: d.oref = q.oref;
        CCM2_OM_SET: d.oref = match ? 1'b1 : q.oref;
        CCM2_OM_CLR: d.oref = match ? 1'b0 : q.oref;
        CCM2_OM_TOG: d.oref = match ? !q.oref : q.oref;
        CCM2_OM_FLO: d.oref = 1'b0;
        CCM2_OM_FHI: d.oref = 1'b1;
        CCM2_OM_PWM1: d.oref = below;
        CCM2_OM_PWM2: d.oref = !below;
        default: d.oref = q.oref;
      endcase
    end
    // fast edge forces the match level for one cycle only
    if (fast_act && trg_edge) begin
      d.oref = om == CCM2_OM_PWM2;
    end

    // input filter: n agreeing samples to change
    d.ti_s = {q.ti_s[0], ch2_timer_input};
    d.div = samp ? 5'h00 : q.div + 5'h01;
    if (code0) begin
      d.filt = q.ti_s[1];
      d.cnt = 4'h0;
    end else if (samp) begin
      if (q.ti_s[1] == q.filt) begin
        d.cnt = 4'h0;
      end else if (q.cnt == flt.n - 4'h1) begin
        d.filt = q.ti_s[1];
        d.cnt = 4'h0;
      end else begin
        d.cnt = q.cnt + 4'h1;
      end
    end
  end

  // reset beats clock enable; ce low freezes all
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.cfg <= CCM2_CFG_RST;
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.arready <= 1'b1;
    end else if (ce) begin
      q <= d;
    end
  end

  // ***********************************************
  // outputs
  // ***********************************************
  assign axi_rsp = '{q.awready, q.wready, q.bvalid, q.bresp,
                     q.arready, q.rvalid, q.rdata, q.rresp};
  assign ch2_output_pin = q.oref;
  assign ch2_filtered = q.filt;
  assign trigger_to_core = q.trg;
  assign ch2_shadow_value = q.shd;

  // ***********************************************
  // assertions
  // ***********************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_unbuf_write: assert property (
    ce && q.aw_got && q.w_got && q.awaddr == CCM2_OFS_CCR &&
    !buf_en && q.wstrb == 4'hf |=> q.shd == CW'($past(q.wdata)))
    else $error("unbuffered write missed shadow");

  a_buf_hold: assert property (
    ce && buf_en && !update_event |=> $stable(q.shd))
    else $error("buffered shadow moved without update");

  a_buf_load: assert property (
    ce && buf_en && update_event |=> q.shd == $past(q.pre))
    else $error("update did not load buffer");

  a_input_hold: assert property (
    ce && !out_dir && trg_edge |=> $stable(q.oref))
    else $error("input channel output moved");

  // pulse must drop again after one enabled cycle
  a_trig_pulse: assert property (
    ce && trg_edge ##1 ce |-> trigger_to_core ##1 !trigger_to_core)
    else $error("trigger pulse wrong");

  a_fast_level: assert property (
    ce && fast_act && trg_edge |=>
    ch2_output_pin == $past(om == CCM2_OM_PWM2))
    else $error("fast trigger level wrong");

  a_frozen_fast: assert property (
    ce && out_dir && om == CCM2_OM_FRZ |=> $stable(ch2_output_pin))
    else $error("frozen output moved");

  a_set_no_fast: assert property (
    ce && out_dir && om == CCM2_OM_SET && !match && trg_edge |=>
    $stable(ch2_output_pin))
    else $error("fast path acted outside pwm");

  a_input_unbuf: assert property (
    ce && !out_dir && q.aw_got && q.w_got && q.awaddr == CCM2_OFS_CCR &&
    q.wstrb == 4'hf |=> q.shd == CW'($past(q.wdata)))
    else $error("buffer bit acted on input channel");

  a_filt_pair: assert property (
    ce && !code0 && fcode == 4'h1 && d.filt != q.filt |->
    $past(q.ti_s[1]) != q.filt)
    else $error("code one changed on one sample");

  a_filt_bypass: assert property (
    ce && !out_dir && fcode == 4'h0 |=> q.filt == $past(q.ti_s[1]))
    else $error("code zero not bypassed");

  a_filt_count: assert property (
    ce && !code0 && d.filt != q.filt |-> samp && q.cnt == flt.n - 4'h1)
    else $error("filter changed early");

  a_code_eleven: assert property (
    ce && !code0 && fcode == 4'hb && d.filt != q.filt |->
    q.cnt == 4'h5 && q.div == 5'h0f)
    else $error("code eleven timing wrong");

  a_reset_clear: assert property (
    $rose(aresetn) |-> q.cfg == CCM2_CFG_RST && !ch2_output_pin)
    else $error("configuration not cleared");

endmodule // ccm2_top

// ==== sim/ccm2_core_model.sv ====
`timescale 1ns/100ps
// ***********************************************
// counter core stand-in
// ***********************************************
module ccm2_core_model
  import ccm2_pkg::*;
#(
  parameter int CW = 16,
  parameter int PERIOD = 40
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic trigger_to_core,
  output logic [CW-1:0] counter_value,
  output logic update_event
);
  // up-counter, restarted by a trigger like a slave-reset core
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      counter_value <= '0;
      update_event <= 1'b0;
    end else if (trigger_to_core || counter_value == CW'(PERIOD - 1)) begin
      counter_value <= '0;
      update_event <= 1'b1;
    end else begin
      counter_value <= counter_value + 1'b1;
      update_event <= 1'b0;
    end
  end
endmodule // ccm2_core_model

// ==== sim/cc_channel2_mode_config_bench.sv ====
`timescale 1ns/100ps
module cc_channel2_mode_config_bench
  import ccm2_pkg::*;
;
  // ***********************************************
  // signals and instances
  // ***********************************************
  localparam int FDIV [16] = '{1,1,1,1,2,2,4,4,8,8,16,16,16,32,32,32};
  localparam int FN [16] = '{1,2,4,8,6,8,6,8,6,8,5,6,8,5,6,8};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic opm = 1'b0;
  logic trig = 1'b0;
  logic tin = 1'b0;
  ccm2_axi_req_s req = '0;
  ccm2_axi_rsp_s rsp;
  logic out_pin, filt, t2c, upd;
  logic [15:0] shadow, cnt;
  logic [1:0] resp;
  logic [31:0] rd;
  int failures = 0;
  int n_tests = 0;

  ccm2_top #(.CW(16)) dut_u (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .axi_req(req), .axi_rsp(rsp), .update_event(upd),
    .one_pulse_select(opm), .counter_value(cnt), .trigger_pin(trig),
    .ch2_timer_input(tin), .ch2_output_pin(out_pin), .ch2_filtered(filt),
    .trigger_to_core(t2c), .ch2_shadow_value(shadow));
  ccm2_core_model #(.CW(16), .PERIOD(40)) core_u (.aclk(aclk),
    .aresetn(aresetn), .trigger_to_core(t2c), .counter_value(cnt),
    .update_event(upd));

  // free-running clock, 100 ns
  initial begin
    forever #50 aclk = ~aclk;
  end

  // ***********************************************
  // helpers
  // ***********************************************
  task automatic test_done;
    $display("checks %0d, failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      failures++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask

  // settle point just after an edge
  task automatic tick(input int k);
    repeat (k) @(posedge aclk);
    #1;
  endtask

  task automatic wait_upd;
    do tick(1); while (upd !== 1'b1);
  endtask

  // aw and w offered together, each dropped when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    req.awaddr <= {24'h0, a};
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
      if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    resp = rsp.bresp;
    req.bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    req.araddr <= {24'h0, a};
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    rd = rsp.rdata;
    resp = rsp.rresp;
    req.rready <= 1'b0;
  endtask

  // ***********************************************
  // scenarios
  // ***********************************************
  task automatic t_regs;
    axr(CCM2_OFS_CFG);
    chk(rd === 32'h0 && resp === CCM2_OKAY, "cfg reset");
    chk(shadow === 16'h0 && filt === 1'b0, "outputs reset");
    axw(CCM2_OFS_CFG, 32'hffffffff);
    axr(CCM2_OFS_CFG);
    chk(rd === 32'h0000ffff, "cfg upper bits");
    axw(CCM2_OFS_CFG, 32'h0);
    axw(8'h0c, 32'h1234);
    chk(resp === CCM2_SLVERR, "unmapped write");
    axr(8'h0c);
    chk(rd === 32'h0 && resp === CCM2_SLVERR, "unmapped read");
  endtask

  task automatic t_buf;
    axw(CCM2_OFS_CCR, 32'h0123);
    tick(1);
    chk(shadow === 16'h0123, "unbuffered write");
    axw(CCM2_OFS_CFG, 32'h0800);
    // start right after an update so none lands mid-write
    wait_upd;
    axw(CCM2_OFS_CCR, 32'h0456);
    tick(1);
    chk(shadow === 16'h0123, "buffered write held");
    axr(CCM2_OFS_CCR);
    chk(rd === 32'h0456, "buffer readback");
    wait_upd;
    tick(1);
    chk(shadow === 16'h0456, "copied on update");
    axw(CCM2_OFS_CFG, 32'h0900);
    axw(CCM2_OFS_CCR, 32'h0789);
    tick(1);
    chk(shadow === 16'h0789, "buffer bit ignored as input");
    // a trigger edge must not reach an input channel's output
    @(posedge aclk);
    trig <= 1'b1;
    tick(4);
    chk(out_pin === 1'b0, "input channel took trigger");
    @(posedge aclk);
    trig <= 1'b0;
    tick(4);
    axw(CCM2_OFS_CFG, 32'h0);
  endtask

  // compare value ffff keeps the normal comparison inactive
  task automatic t_trig(input logic [31:0] cfg, input logic exp3);
    axw(CCM2_OFS_CFG, cfg);
    tick(2);
    chk(out_pin === 1'b0, "idle low");
    @(posedge aclk);
    trig <= 1'b1;
    tick(2);
    chk(out_pin === 1'b0 && t2c === 1'b0, "early response");
    tick(1);
    chk(out_pin === exp3 && t2c === 1'b1, "third edge");
    tick(2);
    chk(out_pin === 1'b0, "fifth edge");
    @(posedge aclk);
    trig <= 1'b0;
    tick(4);
  endtask

  // normal path: core restart shows on the pin at the fifth edge
  task automatic t_norm;
    axw(CCM2_OFS_CFG, 32'h6000);
    axw(CCM2_OFS_CCR, 32'h0001);
    axr(CCM2_OFS_STAT);
    chk(rd[2] === 1'b0, "one-pulse pwm flagged");
    // start just after an update so no natural zero lands nearby
    wait_upd;
    tick(4);
    @(posedge aclk);
    trig <= 1'b1;
    tick(4);
    chk(out_pin === 1'b0, "normal path too fast");
    tick(1);
    chk(out_pin === 1'b1, "normal path fifth edge");
    @(posedge aclk);
    trig <= 1'b0;
    axw(CCM2_OFS_CFG, 32'h5000);
    tick(1);
    chk(out_pin === 1'b1, "forced high");
    axw(CCM2_OFS_CFG, 32'h4000);
    tick(1);
    chk(out_pin === 1'b0, "forced low");
  endtask

  // disabled clock freezes the whole channel, syncs too
  task automatic t_hold;
    axw(CCM2_OFS_CFG, 32'h0100);
    tick(2);
    @(posedge aclk);
    ce <= 1'b0;
    tin <= 1'b1;
    tick(5);
    chk(filt === 1'b0, "moved while disabled");
    @(posedge aclk);
    ce <= 1'b1;
    tick(3);
    chk(filt === 1'b1, "resume after enable");
    @(posedge aclk);
    tin <= 1'b0;
    tick(4);
  endtask

  task automatic t_flt(input int k);
    int c;
    int d;
    int n;
    d = FDIV[k];
    n = FN[k];
    c = 0;
    axw(CCM2_OFS_CFG, {16'h0, 4'(k), 12'h100});
    tick(n * d * 2 + 8);
    // a pulse of n-1 sample periods cannot gather n samples
    if (n > 1) begin
      @(posedge aclk);
      tin <= 1'b1;
      repeat ((n - 1) * d) @(posedge aclk);
      tin <= 1'b0;
      repeat ((n + 2) * d + 4) begin
        tick(1);
        if (filt !== 1'b0) c++;
      end
      chk(c == 0, "glitch rejected");
      c = 0;
    end
    @(posedge aclk);
    tin <= 1'b1;
    while (filt !== 1'b1 && c < (n + 1) * d + 6) begin
      tick(1);
      c++;
    end
    // two sync edges, up to d-1 of phase, n samples, one register
    chk(c >= (n - 1) * d + 3 && c <= n * d + 2, "filter delay");
    if (k == 0) chk(c == 3, "unfiltered delay");
    @(posedge aclk);
    tin <= 1'b0;
    tick((n + 1) * d + 6);
    chk(filt === 1'b0, "filter falls");
  endtask

  // ***********************************************
  // main sequence and watchdog
  // ***********************************************
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    tick(1);
    t_regs;
    t_buf;
    axw(CCM2_OFS_CCR, 32'h0000ffff);
    @(posedge aclk);
    opm <= 1'b1;
    t_trig(32'h7000, 1'b0);
    t_trig(32'h1400, 1'b0);
    t_trig(32'h7400, 1'b1);
    t_norm;
    t_hold;
    for (int k = 0; k < 16; k++) t_flt(k);
    // second reset in mid-run must clear the last filter setup
    @(posedge aclk);
    aresetn <= 1'b0;
    tick(2);
    @(posedge aclk);
    aresetn <= 1'b1;
    tick(1);
    axr(CCM2_OFS_CFG);
    chk(rd === 32'h0 && resp === CCM2_OKAY, "cfg after reset");
    test_done;
  end

  // whole run needs well under 20000 cycles
  initial begin
    #(60000 * 100);
    failures++;
    $display("mismatch at %0t: timeout", $time);
    test_done;
  end
endmodule // cc_channel2_mode_config_bench
